/* File: logic/rbas_defines.vh */
/*
  Constants shared by the random buffer access server and its word store.
  Assumes inclusion by bare name from files under logic/.
*/
`ifndef RBAS_DEFINES_VH
`define RBAS_DEFINES_VH

// ****************************************************************
// Command and completion codes
// ****************************************************************
`define RBAS_TYPE_WR      8'h61
`define RBAS_TYPE_RD      8'h62
`define RBAS_RESP_BIT     8'h80
`define RBAS_CODE_OK      8'h00
`define RBAS_CODE_TYPE    8'h50
`define RBAS_CODE_ADDR    8'h51
`define RBAS_CODE_LEN     8'h52
`define RBAS_CODE_ASCII   8'h54

// ****************************************************************
// Buffer geometry
// ****************************************************************
`define RBAS_LAST_ADDR    17'h017FF
`define RBAS_WORDS        17'h01800
`define RBAS_MEM_WORDS    13'h1800
`define RBAS_CH_WORDS     13'h0C00
`define RBAS_MAX_BIN      16'h03F9
`define RBAS_MAX_ASC      16'h01FC

// ****************************************************************
// Frame layout
// ****************************************************************
`define RBAS_UNIT_BIN     3'h2
`define RBAS_UNIT_ASC     3'h4
`define RBAS_FLD_LEN      2'h2
`define RBAS_FLD_DATA     2'h3

// ****************************************************************
// ASCII hex characters
// ****************************************************************
`define RBAS_CH_0         8'h30
`define RBAS_CH_9         8'h39
`define RBAS_CH_UA        8'h41
`define RBAS_CH_UF        8'h46
`define RBAS_CH_LA        8'h61
`define RBAS_CH_LF        8'h66
`define RBAS_NIB_A        4'hA

`endif

/* File: logic/rbas_store.v */
/*
  Single-port 6K x 16 word store of the random buffer access server.
  Assumes one clock, a clock enable, and a caller that arbitrates access.
*/
`timescale 1ns/1ns
`include "rbas_defines.vh"

module rbas_store (
  sys_clk,
  ce,
  we,
  addr,
  wdata,
  rdata
);
  input  wire        sys_clk;
  input  wire        ce;
  input  wire        we;
  input  wire [12:0] addr;
  input  wire [15:0] wdata;
  output reg  [15:0] rdata;

  // Volatile storage, no reset and no retention
  reg [15:0] mem [0:6143];

  // ****************************************************************
  // Registered read, write-through-free write
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (ce) begin
      if (we && (addr < `RBAS_MEM_WORDS)) begin
        mem[addr] <= wdata;
      end
      if (addr < `RBAS_MEM_WORDS) begin
        rdata <= mem[addr];
      end else begin
        rdata <= 16'h0000;
      end
    end
  end
endmodule // rbas_store

/* File: logic/rbas_server.v */
/*
  Random buffer access server: parses remote write and read commands in
  binary or ASCII framing, serves those on open connections from a shared
  word store, and answers them with a completion code. Also serves local CPU word accesses.
  Assumes byte streams with valid/ready handshakes, one frame per rx_last,
  and a static code_ascii setting.
*/
`timescale 1ns/1ns
`include "rbas_defines.vh"

module rbas_server (
  sys_clk,
  reset,
  ce,
  code_ascii,
  connection_open_complete,
  rx_valid,
  rx_data,
  rx_last,
  rx_conn,
  rx_ready,
  tx_valid,
  tx_data,
  tx_last,
  tx_conn,
  tx_ready,
  local_buffer_read_write_req,
  local_write,
  local_addr,
  local_wdata,
  buffer_channel_select,
  local_ack,
  local_rdata,
  remote_busy
);
  input  wire        sys_clk;
  input  wire        reset;
  input  wire        ce;
  input  wire        code_ascii;
  input  wire [7:0]  connection_open_complete;
  input  wire        rx_valid;
  input  wire [7:0]  rx_data;
  input  wire        rx_last;
  input  wire [2:0]  rx_conn;
  output reg         rx_ready;
  output reg         tx_valid;
  output reg  [7:0]  tx_data;
  output reg         tx_last;
  output reg  [2:0]  tx_conn;
  input  wire        tx_ready;
  input  wire        local_buffer_read_write_req;
  input  wire        local_write;
  input  wire [11:0] local_addr;
  input  wire [15:0] local_wdata;
  input  wire        buffer_channel_select;
  output reg         local_ack;
  output reg  [15:0] local_rdata;
  output reg         remote_busy;

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RX   = 3'h1;
  localparam [2:0] ST_TXH  = 3'h2;
  localparam [2:0] ST_TXF  = 3'h3;
  localparam [2:0] ST_TXL  = 3'h4;
  localparam [2:0] ST_TXD  = 3'h5;
  localparam [2:0] ST_TXE  = 3'h6;
  localparam [2:0] ST_LOC  = 3'h7;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Value of an ASCII hex digit, upper or lower case
  function [3:0] hex_val;
    input [7:0] c;
    begin
      if (c >= `RBAS_CH_LA) begin
        hex_val = c[3:0] + 4'h9;
      end else if (c >= `RBAS_CH_UA) begin
        hex_val = c[3:0] + 4'h9;
      end else begin
        hex_val = c[3:0];
      end
    end
  endfunction

  // High when a character is no hex digit
  function hex_bad;
    input [7:0] c;
    begin
      hex_bad = !(((c >= `RBAS_CH_0) && (c <= `RBAS_CH_9)) ||
                  ((c >= `RBAS_CH_UA) && (c <= `RBAS_CH_UF)) ||
                  ((c >= `RBAS_CH_LA) && (c <= `RBAS_CH_LF)));
    end
  endfunction

  // Upper-case ASCII hex digit of a nibble
  function [7:0] hex_char;
    input [3:0] n;
    begin
      if (n < `RBAS_NIB_A) begin
        hex_char = `RBAS_CH_0 + {4'h0, n};
      end else begin
        hex_char = `RBAS_CH_UA + {4'h0, n - `RBAS_NIB_A};
      end
    end
  endfunction

  // Byte idx of a 16-bit unit: binary low first, ASCII MSD first
  function [7:0] unit_byte;
    input [15:0] u;
    input [2:0]  idx;
    input        asc;
    begin
      if (!asc) begin
        unit_byte = (idx == 3'h0) ? u[7:0] : u[15:8];
      end else begin
        case (idx[1:0])
          2'h0:    unit_byte = hex_char(u[15:12]);
          2'h1:    unit_byte = hex_char(u[11:8]);
          2'h2:    unit_byte = hex_char(u[7:4]);
          default: unit_byte = hex_char(u[3:0]);
        endcase
      end
    end
  endfunction

  // Header check once type, address and length are known
  function [7:0] check_code;
    input [7:0]  typ;
    input [15:0] addr;
    input [15:0] len;
    input        asc;
    reg   [16:0] end_addr;
    begin
      end_addr = {1'b0, addr} + {1'b0, len};
      if ((typ != `RBAS_TYPE_WR) && (typ != `RBAS_TYPE_RD)) begin
        check_code = `RBAS_CODE_TYPE;
      end else if ({1'b0, addr} > `RBAS_LAST_ADDR) begin
        check_code = `RBAS_CODE_ADDR;
      end else if (end_addr > `RBAS_WORDS) begin
        check_code = `RBAS_CODE_LEN;
      end else if (len > (asc ? `RBAS_MAX_ASC : `RBAS_MAX_BIN)) begin
        check_code = `RBAS_CODE_LEN;
      end else begin
        check_code = `RBAS_CODE_OK;
      end
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [2:0]  fpos;
  reg [1:0]  field;
  reg [15:0] acc;
  reg [7:0]  type_r;
  reg [15:0] len_r;
  reg [12:0] cur_addr;
  reg [9:0]  words_left;
  reg [7:0]  code;
  reg [7:0]  next_code;
  reg        conn_ok;
  reg [2:0]  tx_pos;
  reg [15:0] tx_word;
  reg [12:0] loc_addr;
  reg        loc_we;
  reg        loc_ok;
  reg [15:0] loc_wdata;
  reg        mem_we;
  reg [12:0] mem_addr;
  reg [15:0] mem_wdata;
  wire [15:0] mem_rdata;

  wire [2:0]  unit_len = code_ascii ? `RBAS_UNIT_ASC : `RBAS_UNIT_BIN;
  wire        in_rx    = (state == ST_IDLE) || (state == ST_RX);
  wire        take     = in_rx && rx_valid && rx_ready;
  wire        unit_end = (fpos == (unit_len - 3'h1));
  wire        bad_now  = code_ascii && hex_bad(rx_data);
  wire [15:0] acc_nxt  = code_ascii ?
                         {acc[11:0], hex_val(rx_data)} :
                         {rx_data, acc[15:8]};
  wire        conn_now = (state == ST_IDLE) ?
                         connection_open_complete[rx_conn] : conn_ok;
  wire        hdr_end  = (field == `RBAS_FLD_LEN) && unit_end;
  wire        short_fr = (field < `RBAS_FLD_LEN) ||
                         ((field == `RBAS_FLD_LEN) && !unit_end);
  wire [15:0] len_fin  = hdr_end ? acc_nxt : len_r;
  wire        wr_fire  = take && conn_ok && (field == `RBAS_FLD_DATA) &&
                         unit_end && (type_r == `RBAS_TYPE_WR) &&
                         (code == `RBAS_CODE_OK) && !bad_now &&
                         (words_left != 10'h000);
  wire [7:0]  rsp_type = type_r | `RBAS_RESP_BIT;
  wire [15:0] hdr_unit = code_ascii ? {rsp_type, code} :
                                      {code, rsp_type};
  wire        tx_free  = !tx_valid || tx_ready;
  wire        tx_uend  = (tx_pos == (unit_len - 3'h1));
  wire [12:0] loc_map  = {1'b0, local_addr} +
                         (buffer_channel_select ? `RBAS_CH_WORDS :
                                                  13'h0000);

  // ****************************************************************
  // Completion code of the frame being received
  // ****************************************************************
  always @* begin
    next_code = code;
    if (take) begin
      if (bad_now) begin
        next_code = `RBAS_CODE_ASCII;
      end else if (hdr_end && (code == `RBAS_CODE_OK)) begin
        next_code = check_code(type_r, {3'h0, cur_addr}, acc_nxt,
                               code_ascii);
      end
      if (rx_last && short_fr && (next_code == `RBAS_CODE_OK)) begin
        next_code = `RBAS_CODE_TYPE;
      end
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take) begin
          next_state = rx_last ? (conn_now ? ST_TXH : ST_IDLE) : ST_RX;
        end else if (!rx_valid && local_buffer_read_write_req &&
                     !local_ack) begin
          next_state = ST_LOC;
        end
      end
      ST_RX: begin
        if (take && rx_last) begin
          next_state = conn_ok ? ST_TXH : ST_IDLE;
        end
      end
      ST_TXH: begin
        if (tx_free && tx_uend) begin
          next_state = (words_left == 10'h000) ? ST_TXE : ST_TXF;
        end
      end
      ST_TXF: begin
        next_state = ST_TXL;
      end
      ST_TXL: begin
        next_state = ST_TXD;
      end
      ST_TXD: begin
        if (tx_free && tx_uend) begin
          next_state = (words_left == 10'h001) ? ST_TXE : ST_TXF;
        end
      end
      ST_TXE: begin
        if (tx_free) begin
          next_state = ST_IDLE;
        end
      end
      ST_LOC: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Store port arbitration: remote owns it outside ST_LOC
  // ****************************************************************
  always @* begin
    if (state == ST_LOC) begin
      mem_addr  = loc_addr;
      mem_we    = loc_we && loc_ok;
      mem_wdata = loc_wdata;
    end else begin
      mem_addr  = cur_addr;
      mem_we    = wr_fire;
      mem_wdata = acc_nxt;
    end
  end

  rbas_store u_store (
    .sys_clk (sys_clk),
    .ce      (ce),
    .we      (mem_we),
    .addr    (mem_addr),
    .wdata   (mem_wdata),
    .rdata   (mem_rdata)
  );

  // ****************************************************************
  // Frame receive, response send and local access
  // ****************************************************************
  always @(posedge sys_clk) begin
    if (reset) begin
      state       <= ST_IDLE;
      fpos        <= 3'h0;
      field       <= 2'h0;
      acc         <= 16'h0000;
      type_r      <= 8'h00;
      len_r       <= 16'h0000;
      cur_addr    <= 13'h0000;
      words_left  <= 10'h000;
      code        <= `RBAS_CODE_OK;
      conn_ok     <= 1'b0;
      tx_pos      <= 3'h0;
      tx_word     <= 16'h0000;
      loc_addr    <= 13'h0000;
      loc_we      <= 1'b0;
      loc_ok      <= 1'b0;
      loc_wdata   <= 16'h0000;
      rx_ready    <= 1'b0;
      tx_valid    <= 1'b0;
      tx_data     <= 8'h00;
      tx_last     <= 1'b0;
      tx_conn     <= 3'h0;
      local_ack   <= 1'b0;
      local_rdata <= 16'h0000;
      remote_busy <= 1'b0;
    end else if (ce) begin
      state       <= next_state;
      rx_ready    <= (next_state == ST_IDLE) || (next_state == ST_RX);
      remote_busy <= (next_state != ST_IDLE) && (next_state != ST_LOC);
      local_ack   <= 1'b0;
      if (tx_valid && tx_ready) begin
        tx_valid <= 1'b0;
        tx_last  <= 1'b0;
      end
      // Receive side: header fields, then data units
      if (take) begin
        code <= next_code;
        acc  <= acc_nxt;
        fpos <= unit_end ? 3'h0 : fpos + 3'h1;
        if (state == ST_IDLE) begin
          conn_ok <= connection_open_complete[rx_conn];
          tx_conn <= rx_conn;
        end
        if (unit_end && (field != `RBAS_FLD_DATA)) begin
          field <= field + 2'h1;
          case (field)
            2'h0:    type_r <= code_ascii ? acc_nxt[15:8] : acc_nxt[7:0];
            2'h1:    cur_addr <= (|acc_nxt[15:13]) ? {13{1'b1}} :
                                 acc_nxt[12:0];
            default: begin
              len_r      <= acc_nxt;
              words_left <= acc_nxt[9:0];
            end
          endcase
        end
        if (wr_fire) begin
          cur_addr   <= cur_addr + 13'h0001;
          words_left <= words_left - 10'h001;
        end
        if (rx_last) begin
          field  <= 2'h0;
          fpos   <= 3'h0;
          tx_pos <= 3'h0;
          if ((type_r == `RBAS_TYPE_RD) && (next_code == `RBAS_CODE_OK) &&
              !short_fr) begin
            words_left <= len_fin[9:0];
            if (hdr_end) begin
              cur_addr <= cur_addr;
            end
          end else begin
            words_left <= 10'h000;
          end
          if (!conn_now) begin
            code <= `RBAS_CODE_OK;
          end
        end
      end
      // Response header: type with reply bit, then completion code
      if ((state == ST_TXH) && tx_free) begin
        tx_valid <= 1'b1;
        tx_data  <= unit_byte(hdr_unit, tx_pos, code_ascii);
        tx_last  <= tx_uend && (words_left == 10'h000);
        tx_pos   <= tx_uend ? 3'h0 : tx_pos + 3'h1;
      end
      // Read data: fetch a word, then send its bytes
      if (state == ST_TXL) begin
        tx_word  <= mem_rdata;
        cur_addr <= cur_addr + 13'h0001;
      end
      if ((state == ST_TXD) && tx_free) begin
        tx_valid <= 1'b1;
        tx_data  <= unit_byte(tx_word, tx_pos, code_ascii);
        tx_last  <= tx_uend && (words_left == 10'h001);
        tx_pos   <= tx_uend ? 3'h0 : tx_pos + 3'h1;
        if (tx_uend) begin
          words_left <= words_left - 10'h001;
        end
      end
      if ((state == ST_TXE) && tx_free) begin
        code <= `RBAS_CODE_OK;
      end
      // Local access only starts when no remote frame is open
      if ((state == ST_IDLE) && (next_state == ST_LOC)) begin
        loc_addr  <= loc_map;
        loc_ok    <= ({1'b0, local_addr} < `RBAS_CH_WORDS);
        loc_we    <= local_write;
        loc_wdata <= local_wdata;
      end
      if (state == ST_LOC) begin
        local_ack <= 1'b1;
      end
      if (local_ack) begin
        local_rdata <= loc_ok ? mem_rdata : 16'h0000;
      end
    end
  end
endmodule // rbas_server

/* File: sim/rbas_remote_node.sv */
/*
  Behavioural remote node: offers request frames byte by byte and
  collects the response bytes, promptly or with stalls.
  Assumes the bench fills frm before send and calls recv after it.
*/
`timescale 1ns/1ns
module rbas_remote_node (
  input  wire       sys_clk,
  output reg        rx_valid,
  output reg  [7:0] rx_data,
  output reg        rx_last,
  output reg  [2:0] rx_conn,
  input  wire       rx_ready,
  input  wire       tx_valid,
  input  wire [7:0] tx_data,
  input  wire       tx_last,
  output reg        tx_ready
);
  logic [7:0] frm[$];
  logic [7:0] rsp[$];
  bit         slow;

  // Idle lines at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'hA5;
    rx_last  = 1'b0;
    rx_conn  = 3'h0;
    tx_ready = 1'b0;
    slow     = 1'b0;
  end

  // Hold each byte until the edge that samples rx_ready high
  task automatic send(input logic [2:0] conn);
    int   i;
    logic r;
    @(posedge sys_clk);
    for (i = 0; i < frm.size(); i++) begin
      #1;
      rx_valid = 1'b1;
      rx_data  = frm[i];
      rx_last  = (i == frm.size() - 1);
      rx_conn  = conn;
      do begin
        @(negedge sys_clk);
        r = rx_ready;
        @(posedge sys_clk);
      end while (!r);
    end
    #1;
    rx_valid = 1'b0;
    rx_last  = 1'b0;
    rx_data  = ~rx_data;
    frm.delete();
  endtask

  // Take response bytes, stalling every other cycle when slow
  task automatic recv();
    int   n;
    logic l;
    rsp.delete();
    l = 1'b0;
    for (n = 0; !l && n < 4000; n++) begin
      @(posedge sys_clk);
      #1;
      tx_ready = !(slow && n[0]);
      @(negedge sys_clk);
      if (tx_valid && tx_ready) begin
        rsp.push_back(tx_data);
        l = tx_last;
      end
    end
    @(posedge sys_clk);
    #1;
    tx_ready = 1'b0;
  endtask
endmodule // rbas_remote_node

/* File: sim/rbas_server_props.sv */
/*
  Port-level checks of the random buffer access server.
  Assumes one clock, synchronous active-high reset, ce held high.
*/
`timescale 1ns/1ns
module rbas_server_props (
  input logic        sys_clk,
  input logic        reset,
  input logic        code_ascii,
  input logic [7:0]  connection_open_complete,
  input logic        rx_valid,
  input logic        rx_last,
  input logic [2:0]  rx_conn,
  input logic        rx_ready,
  input logic        tx_valid,
  input logic [7:0]  tx_data,
  input logic        tx_last,
  input logic [2:0]  tx_conn,
  input logic        tx_ready,
  input logic        local_buffer_read_write_req,
  input logic        local_ack,
  input logic        remote_busy
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // Frame end and connection-open conditions
  wire fin  = rx_valid && rx_ready && rx_last;
  wire open = connection_open_complete[rx_conn];

  a_ready_after_reset: assert property ($fell(reset) |=> rx_ready)
    else $error("rx_ready not up after reset");
  a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid &&
    $stable(tx_data) && $stable(tx_last) && $stable(tx_conn))
    else $error("response byte changed while stalled");
  a_rx_stops: assert property (fin |=> (rx_ready != $past(open)))
    else $error("rx_ready high after frame end");
  a_reply_starts: assert property (fin && open |-> ##[1:4] tx_valid)
    else $error("no response to open connection");
  a_closed_silent: assert property (fin && !open |=> !tx_valid [*8])
    else $error("response to closed connection");
  a_resp_bin_type: assert property ($rose(tx_valid) &&
    $past(rx_ready, 2) && !code_ascii |-> tx_data[7])
    else $error("binary response type lacks 80h");
  a_ack_pulse: assert property (local_ack |=> !local_ack)
    else $error("local_ack longer than one cycle");
  a_ack_not_busy: assert property (local_ack |-> !remote_busy)
    else $error("local access done during remote exchange");
  a_local_served: assert property (local_buffer_read_write_req &&
    !local_ack && rx_ready && !rx_valid && !remote_busy
    |-> ##[1:3] local_ack)
    else $error("idle local access not served");
  a_tx_busy: assert property (tx_valid |-> remote_busy)
    else $error("response byte without remote_busy");
endmodule // rbas_server_props

bind rbas_server rbas_server_props i_rbas_server_props (
  .sys_clk(sys_clk), .reset(reset), .code_ascii(code_ascii),
  .connection_open_complete(connection_open_complete),
  .rx_valid(rx_valid), .rx_last(rx_last), .rx_conn(rx_conn),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_last(tx_last), .tx_conn(tx_conn), .tx_ready(tx_ready),
  .local_buffer_read_write_req(local_buffer_read_write_req),
  .local_ack(local_ack), .remote_busy(remote_busy)
);

/* File: sim/rbas_server_bench.sv */
/*
  Self-checking bench of the random buffer access server.
  Assumes a 20 MHz clock and the remote node model beside the design.
*/
`timescale 1ns/1ns
module rbas_server_bench;
  logic        sys_clk, reset, ce, code_ascii;
  logic [7:0]  connection_open_complete;
  logic        local_buffer_read_write_req, local_write;
  logic        buffer_channel_select;
  logic [11:0] local_addr;
  logic [15:0] local_wdata, rd;
  wire         rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
  wire  [7:0]  rx_data, tx_data;
  wire  [2:0]  rx_conn, tx_conn;
  wire         local_ack, remote_busy;
  wire  [15:0] local_rdata;
  logic [7:0]  q[$];
  logic [15:0] wd[$];
  int          err_count, cmp_count, cyc;

  rbas_server i_rbas_server (
    .sys_clk(sys_clk), .reset(reset), .ce(ce), .code_ascii(code_ascii),
    .connection_open_complete(connection_open_complete),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_conn(rx_conn), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_conn(tx_conn),
    .tx_ready(tx_ready),
    .local_buffer_read_write_req(local_buffer_read_write_req),
    .local_write(local_write), .local_addr(local_addr),
    .local_wdata(local_wdata), .buffer_channel_select(buffer_channel_select),
    .local_ack(local_ack), .local_rdata(local_rdata),
    .remote_busy(remote_busy));

  rbas_remote_node i_rbas_remote_node (
    .sys_clk(sys_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_conn(rx_conn), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready));

  // ********************
  // Helpers
  // ********************
  always #25 sys_clk = ~sys_clk;

  // Cut a hang short
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction

  // Append one 16-bit field in the current framing
  task automatic fld(input logic [15:0] v);
    int k;
    if (code_ascii)
      for (k = 3; k >= 0; k--) q.push_back(hexc(v[4*k +: 4]));
    else begin
      q.push_back(v[7:0]);
      q.push_back(v[15:8]);
    end
  endtask

  task automatic do_reset(input logic a);
    @(posedge sys_clk);
    #1;
    reset = 1'b1;
    code_ascii = a;
    repeat (8) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask

  // Send one command, then judge the whole response when sent on connection 1
  task automatic xfer(input logic [2:0] cn, input logic [7:0] ty,
                      input logic [15:0] ad, ln, input int nw, nr,
                      input logic [7:0] cd, input bit bad);
    int i;
    q.delete();
    fld(code_ascii ? {ty, 8'h00} : {8'h00, ty});
    fld(ad);
    fld(ln);
    for (i = 0; i < nw; i++) fld(wd[i]);
    if (bad) q[q.size() - 1] = 8'h47;
    i_rbas_remote_node.frm = q;
    i_rbas_remote_node.send(cn);
    if (cn != 3'h1) return;
    i_rbas_remote_node.recv();
    q.delete();
    fld(code_ascii ? {ty | 8'h80, cd} : {cd, ty | 8'h80});
    for (i = 0; i < nr; i++) fld(wd[i]);
    chk("rsp_len", 16'(q.size()), 16'(i_rbas_remote_node.rsp.size()));
    chk("tx_conn", {13'h0000, cn}, {13'h0000, tx_conn});
    foreach (q[j])
      chk("rsp_byte", {8'h00, q[j]}, {8'h00, i_rbas_remote_node.rsp[j]});
  endtask

  // One local word access, held until acknowledged
  task automatic lacc(input logic ch, wr, input logic [11:0] a,
                      input logic [15:0] d, output logic [15:0] o);
    int   n;
    logic r;
    @(posedge sys_clk);
    #1;
    buffer_channel_select = ch;
    local_write = wr;
    local_addr = a;
    local_wdata = d;
    local_buffer_read_write_req = 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk);
      r = local_ack;
      @(posedge sys_clk);
      n++;
    end while (!r && n < 200);
    chk("local_ack", 16'h0001, {15'h0000, r});
    #1;
    local_buffer_read_write_req = 1'b0;
    @(negedge sys_clk);
    o = local_rdata;
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic t_bin_wr_rd();
    wd = '{16'h1234, 16'hABCD};
    xfer(3'h1, 8'h61, 16'h17FE, 16'h0002, 2, 0, 8'h00, 0);
    i_rbas_remote_node.slow = 1'b1;
    xfer(3'h1, 8'h62, 16'h17FE, 16'h0002, 0, 2, 8'h00, 0);
    i_rbas_remote_node.slow = 1'b0;
  endtask

  task automatic t_bin_err();
    xfer(3'h1, 8'h63, 16'h0000, 16'h0001, 0, 0, 8'h50, 0);
    xfer(3'h1, 8'h62, 16'h1800, 16'h0001, 0, 0, 8'h51, 0);
    xfer(3'h1, 8'h61, 16'h17FF, 16'h0002, 2, 0, 8'h52, 0);
    xfer(3'h1, 8'h62, 16'h0000, 16'h03FA, 0, 0, 8'h52, 0);
  endtask

  task automatic t_closed();
    logic seen;
    wd = '{16'h0BAD};
    xfer(3'h2, 8'h61, 16'h17FE, 16'h0001, 1, 0, 8'h00, 0);
    seen = 1'b0;
    repeat (20) begin
      @(negedge sys_clk);
      seen |= tx_valid;
    end
    chk("silent", 16'h0000, {15'h0000, seen});
    lacc(1'b1, 1'b0, 12'hBFE, 16'h0000, rd);
    chk("closed_kept", 16'h1234, rd);
  endtask

  task automatic t_local();
    int c;
    for (c = 0; c < 2; c++) begin
      lacc(c[0], 1'b1, 12'h005, 16'(16'h5A00 + c), rd);
      wd = '{16'(16'h5A00 + c)};
      xfer(3'h1, 8'h62, 16'(16'h0005 + 16'h0C00 * c), 16'h0001,
           0, 1, 8'h00, 0);
    end
    wd = '{16'h0001, 16'h0002, 16'h0003, 16'h0004};
    fork
      xfer(3'h1, 8'h61, 16'h0064, 16'h0004, 4, 0, 8'h00, 0);
      begin
        repeat (3) @(posedge sys_clk);
        lacc(1'b0, 1'b0, 12'h067, 16'h0000, rd);
      end
    join
    chk("stalled_rd", 16'h0004, rd);
  endtask

  task automatic t_ascii();
    do_reset(1'b1);
    wd = '{16'h12AB};
    xfer(3'h1, 8'h61, 16'h0200, 16'h0001, 1, 0, 8'h00, 0);
    xfer(3'h1, 8'h62, 16'h0200, 16'h0001, 0, 1, 8'h00, 0);
    xfer(3'h1, 8'h62, 16'h0000, 16'h01FD, 0, 0, 8'h52, 0);
    xfer(3'h1, 8'h61, 16'h0000, 16'h0001, 1, 0, 8'h54, 1);
    lacc(1'b0, 1'b0, 12'h200, 16'h0000, rd);
    chk("ascii_store", 16'h12AB, rd);
  endtask

  // ********************
  // Main sequence
  // ********************
  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    code_ascii = 1'b0;
    connection_open_complete = 8'h02;
    local_buffer_read_write_req = 1'b0;
    local_write = 1'b0;
    local_addr = 12'h000;
    local_wdata = 16'h0000;
    buffer_channel_select = 1'b0;
    do_reset(1'b0);
    t_bin_wr_rd();
    t_bin_err();
    t_closed();
    t_local();
    t_ascii();
    end_of_test();
  end
endmodule // rbas_server_bench
